// *** src/msm_pkg.sv ***
// constants and types for the module stop and mode transition block
// Overview of operation
// [R1] control bit 4 stops i2c channel two
// [R2] control bit 3 stops fifo serial port
// [R3] bit 2 timer two, bit 1 timers 0/1
// [R4] control bit 0 stops both pwm timers
// [R5] software keeps reserved stop bits at one
// [R6] sleep request moves execution to halt
// [R7] interrupt returns halt to execution
// [R8] reset request forces reset state always; the code ignores it while ce is low
// [R9] only peripherals with stop set are stopped
// [R10] reset-type stop initialises, retain-type keeps registers
// [R11] stop bit one gates peripheral clock off
`default_nettype none
package msm_pkg;
   localparam int MSM_NPER = 5;
   // register byte addresses
   localparam logic [31:0] MSM_OFF_CTRL_A = 32'h0000_0000;
   localparam logic [31:0] MSM_OFF_CTRL_B = 32'h0000_0004;
   localparam logic [31:0] MSM_OFF_MODE = 32'h0000_0008;
   // reset values
   localparam logic [7:0] MSM_CTRL_A_RST = 8'hff;
   localparam logic [7:0] MSM_CTRL_B_RST = 8'hff;
   // bit positions in module_stop_ctrl_b, also peripheral index
   localparam int MSM_BIT_STOP_PWM_TIMERS = 0;
   localparam int MSM_BIT_STOP_CYCLE_TIMER01 = 1;
   localparam int MSM_BIT_STOP_CYCLE_TIMER2 = 2;
   localparam int MSM_BIT_STOP_FIFO_SERIAL = 3;
   localparam int MSM_BIT_STOP_I2C_CH2 = 4;
   // peripherals stopped with reset semantics; the rest retain
   localparam logic [4:0] MSM_RESET_SEM = 5'h01;
   // axi responses
   localparam logic [1:0] MSM_RESP_OKAY = 2'h0;
   localparam logic [1:0] MSM_RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      MSM_RESET = 3'h1,
      MSM_EXEC = 3'h2,
      MSM_HALT = 3'h4
   } msm_mode_e;
endpackage
`default_nettype wire

// *** src/msm_gate_if.sv ***
// interface between the control registers and the peripheral gates
`default_nettype none
interface msm_gate_if;
   logic [4:0] stop;
   logic [4:0] clk_en;
   logic [4:0] prst;
   modport ctl (output stop, input clk_en, input prst);
   modport gate (input stop, output clk_en, output prst);
endinterface
`default_nettype wire

// *** src/msm_gate.sv ***
// per-peripheral clock enable and reset generation
`default_nettype none
module msm_gate (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // stop bits in, enables out
   msm_gate_if.gate gif
);
   typedef struct packed {
      logic [4:0] clk_en;
      logic [4:0] prst;
   } msm_gate_s;

   msm_gate_s q;
   msm_gate_s d;
   logic [4:0] en_w;
   logic [4:0] rst_w;

   // clock enable rather than a gated clock: keeps one clock tree
   for (genvar i = 0; i < msm_pkg::MSM_NPER; i++) begin : g_per
      assign en_w[i] = !gif.stop[i]; // R9 R11
      assign rst_w[i] = gif.stop[i] && msm_pkg::MSM_RESET_SEM[i]; // R10
   end

   always_comb begin
      d = q;
      d.clk_en = en_w;
      d.prst = rst_w;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign gif.clk_en = q.clk_en;
   assign gif.prst = q.prst;

   property p_run_when_clear;
      @(posedge clk) disable iff (sys_rst)
         !sys_rst && ce && !gif.stop[3] |=> gif.clk_en[3];
   endproperty
   a_run_when_clear: assert property (p_run_when_clear) // R9
      else $error("clear stop bit did not run peripheral");

   property p_gate_when_set;
      @(posedge clk) disable iff (sys_rst)
         !sys_rst && ce && gif.stop[4] |=> !gif.clk_en[4] && !gif.prst[4];
   endproperty
   a_gate_when_set: assert property (p_gate_when_set) // R11
      else $error("set stop bit left clock running");

   property p_reset_sem;
      @(posedge clk) disable iff (sys_rst)
         !sys_rst && ce && gif.stop[0] |=> gif.prst[0] && !gif.clk_en[0];
   endproperty
   a_reset_sem: assert property (p_reset_sem) // R10
      else $error("pwm stop did not assert peripheral reset");

   property p_retain_sem;
      @(posedge clk) disable iff (sys_rst)
         !sys_rst && ce && gif.stop[2] |=> !gif.clk_en[2] && gif.prst[4:1] == 4'h0;
   endproperty
   a_retain_sem: assert property (p_retain_sem) // R10
      else $error("retained peripheral was reset");
endmodule
`default_nettype wire

// *** src/msm_top.sv ***
// module stop registers, operating mode sequencer and axi4-lite slave
`default_nettype none
module msm_top (
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // axi4-lite write
   input wire logic [31:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // axi4-lite read
   input wire logic [31:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // cpu events
   input wire logic sleep_req,
   input wire logic irq_req,
   input wire logic rst_req,
   output logic [2:0] mode_state,
   // peripheral controls, index = stop bit position
   output logic [4:0] periph_clk_en,
   output logic [4:0] periph_rst
);
   typedef struct packed {
      logic [7:0] ctl_a;
      logic [7:0] ctl_b;
      msm_pkg::msm_mode_e mode;
      logic aw_have;
      logic [31:0] aw_addr;
      logic w_have;
      logic [7:0] w_data;
      logic w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } msm_top_s;

   localparam msm_top_s RST = '{
      ctl_a: msm_pkg::MSM_CTRL_A_RST,
      ctl_b: msm_pkg::MSM_CTRL_B_RST,
      mode: msm_pkg::MSM_RESET,
      aw_addr: 32'h0000_0000,
      w_data: 8'h00,
      bresp: 2'h0,
      rdata: 32'h0000_0000,
      rresp: 2'h0,
      default: 1'b0
   };

   msm_top_s q;
   msm_top_s d;
   logic wr_go;
   msm_gate_if gif ();

   // readies drop while frozen so no beat is taken and lost
   assign s_awready = ce && !q.aw_have && !q.bvalid;
   assign s_wready = ce && !q.w_have && !q.bvalid;
   assign s_arready = ce && !q.rvalid;
   assign wr_go = q.aw_have && q.w_have;

   always_comb begin
      d = q;
      if (s_awvalid && s_awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         d.w_have = 1'b1;
         d.w_data = s_wdata[7:0];
         d.w_strb = s_wstrb[0];
      end
      if (wr_go) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = msm_pkg::MSM_RESP_OKAY;
         // reserved bits stay writable; software keeps them at one
         if (q.aw_addr == msm_pkg::MSM_OFF_CTRL_A) begin
            if (q.w_strb) d.ctl_a = q.w_data; // R5
         end else if (q.aw_addr == msm_pkg::MSM_OFF_CTRL_B) begin
            if (q.w_strb) d.ctl_b = q.w_data; // R1 R2 R3 R4
         end else if (q.aw_addr == msm_pkg::MSM_OFF_MODE) begin
            d.bresp = msm_pkg::MSM_RESP_OKAY;
         end else begin
            d.bresp = msm_pkg::MSM_RESP_SLVERR;
         end
      end
      if (q.bvalid && s_bready) d.bvalid = 1'b0;
      if (s_arvalid && s_arready) begin
         d.rvalid = 1'b1;
         d.rresp = msm_pkg::MSM_RESP_OKAY;
         if (s_araddr == msm_pkg::MSM_OFF_CTRL_A) begin
            d.rdata = {24'h00_0000, q.ctl_a};
         end else if (s_araddr == msm_pkg::MSM_OFF_CTRL_B) begin
            d.rdata = {24'h00_0000, q.ctl_b};
         end else if (s_araddr == msm_pkg::MSM_OFF_MODE) begin
            d.rdata = {29'h0, q.mode};
         end else begin
            d.rdata = 32'h0000_0000;
            d.rresp = msm_pkg::MSM_RESP_SLVERR;
         end
      end
      if (q.rvalid && s_rready) d.rvalid = 1'b0;
      // mode sequencer; the reset request outranks everything
      case (q.mode)
         msm_pkg::MSM_RESET: begin
            d.mode = msm_pkg::MSM_EXEC;
         end
         msm_pkg::MSM_EXEC: begin
            if (sleep_req) d.mode = msm_pkg::MSM_HALT; // R6
         end
         msm_pkg::MSM_HALT: begin
            if (irq_req) d.mode = msm_pkg::MSM_EXEC; // R7
         end
         default: begin
            d.mode = msm_pkg::MSM_RESET;
         end
      endcase
      if (rst_req) d.mode = msm_pkg::MSM_RESET; // R8
      // the reset state reinitialises the stop registers
      if (q.mode == msm_pkg::MSM_RESET) begin
         d.ctl_a = msm_pkg::MSM_CTRL_A_RST;
         d.ctl_b = msm_pkg::MSM_CTRL_B_RST;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= RST;
      end else if (ce) begin
         q <= d;
      end
   end

   assign gif.stop = q.ctl_b[4:0]; // R9
   msm_gate u_gate (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .gif(gif)
   );

   assign s_bvalid = q.bvalid;
   assign s_bresp = q.bresp;
   assign s_rvalid = q.rvalid;
   assign s_rdata = q.rdata;
   assign s_rresp = q.rresp;
   assign mode_state = q.mode;
   assign periph_clk_en = gif.clk_en;
   assign periph_rst = gif.prst;

   logic wr_b;
   assign wr_b = ce && wr_go && q.w_strb && q.mode != msm_pkg::MSM_RESET
      && q.aw_addr == msm_pkg::MSM_OFF_CTRL_B;

   property p_i2c_bit;
      @(posedge clk) disable iff (sys_rst)
         wr_b |=> q.ctl_b[4] == $past(q.w_data[4]) ##1 gif.clk_en[4] == !q.ctl_b[4];
   endproperty
   a_i2c_bit: assert property (p_i2c_bit) // R1
      else $error("i2c stop bit not written or not applied");

   property p_reset_ones;
      @(posedge clk) disable iff (sys_rst)
         $past(sys_rst) |-> q.ctl_b == 8'hff && q.ctl_a == 8'hff;
   endproperty
   a_reset_ones: assert property (p_reset_ones) // R1 R2 R3 R4
      else $error("stop registers not all ones after reset");

   property p_fifo_read;
      @(posedge clk) disable iff (sys_rst)
         s_arvalid && s_arready && s_araddr == msm_pkg::MSM_OFF_CTRL_B
         |=> s_rvalid && s_rdata[3] == $past(q.ctl_b[3]);
   endproperty
   a_fifo_read: assert property (p_fifo_read) // R2
      else $error("fifo serial stop bit read back wrong");

   property p_timer_bits;
      @(posedge clk) disable iff (sys_rst)
         wr_b |=> q.ctl_b[2:1] == $past(q.w_data[2:1]);
   endproperty
   a_timer_bits: assert property (p_timer_bits) // R3
      else $error("cycle timer stop bits not written");

   property p_pwm_bit;
      @(posedge clk) disable iff (sys_rst)
         wr_b && q.w_data[0] |=> ce [*2] |-> periph_rst[0];
   endproperty
   a_pwm_bit: assert property (p_pwm_bit) // R4
      else $error("pwm stop bit did not reset pwm timers");

   property p_sleep;
      @(posedge clk) disable iff (sys_rst)
         ce && !rst_req && q.mode == msm_pkg::MSM_EXEC && sleep_req
         |=> q.mode == msm_pkg::MSM_HALT;
   endproperty
   a_sleep: assert property (p_sleep) // R6
      else $error("sleep did not halt");

   property p_wake;
      @(posedge clk) disable iff (sys_rst)
         ce && !rst_req && q.mode == msm_pkg::MSM_HALT && irq_req
         |=> q.mode == msm_pkg::MSM_EXEC;
   endproperty
   a_wake: assert property (p_wake) // R7
      else $error("interrupt did not resume execution");

   property p_force_reset;
      @(posedge clk) disable iff (sys_rst)
         ce && rst_req |=> q.mode == msm_pkg::MSM_RESET ##0 ce |=> q.ctl_b == 8'hff;
   endproperty
   a_force_reset: assert property (p_force_reset) // R8
      else $error("reset request did not force reset state");

   c_sleep_wake: cover property (@(posedge clk) disable iff (sys_rst)
      q.mode == msm_pkg::MSM_HALT ##1 q.mode == msm_pkg::MSM_EXEC);
   c_write_b: cover property (@(posedge clk) disable iff (sys_rst)
      wr_b && q.w_data[4:0] == 5'h00);
   c_read_err: cover property (@(posedge clk) disable iff (sys_rst)
      s_rvalid && s_rresp == msm_pkg::MSM_RESP_SLVERR);
endmodule
`default_nettype wire

// *** tb/test_module_stop_and_mode_transition.sv ***
// self-checking bench for the module stop and mode transition block
`default_nettype none
module test_module_stop_and_mode_transition;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic [31:0] s_awaddr = 32'h0;
   logic s_awvalid = 1'b0;
   logic s_awready;
   logic [31:0] s_wdata = 32'h0;
   logic [3:0] s_wstrb = 4'h0;
   logic s_wvalid = 1'b0;
   logic s_wready;
   logic [1:0] s_bresp;
   logic s_bvalid;
   logic s_bready = 1'b0;
   logic [31:0] s_araddr = 32'h0;
   logic s_arvalid = 1'b0;
   logic s_arready;
   logic [31:0] s_rdata;
   logic [1:0] s_rresp;
   logic s_rvalid;
   logic s_rready = 1'b0;
   logic sleep_req = 1'b0;
   logic irq_req = 1'b0;
   logic rst_req = 1'b0;
   logic [2:0] mode_state;
   logic [4:0] periph_clk_en;
   logic [4:0] periph_rst;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [1:0] rsp;
   logic [3:0] wr_strb = 4'hf;

   msm_top u_msm_top (.clk(clk), .sys_rst(sys_rst), .ce(ce), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .sleep_req(sleep_req), .irq_req(irq_req), .rst_req(rst_req),
      .mode_state(mode_state), .periph_clk_en(periph_clk_en), .periph_rst(periph_rst));

   always #20 clk = ~clk;

   // a hung handshake must still end the run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count = err_count + 1;
         complete_run();
      end
   end

   task automatic complete_run();
      if (err_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         err_count = err_count + 1;
      end
   endtask

   // readies are combinational: sample them mid-cycle, act at the next edge
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      logic at;
      logic wt;
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      // start right after a rising edge, whatever the caller waited on
      @(posedge clk);
      s_awaddr <= a;
      s_awvalid <= 1'b1;
      s_wdata <= d;
      s_wstrb <= wr_strb;
      s_wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge clk);
         at = s_awvalid && s_awready;
         wt = s_wvalid && s_wready;
         @(posedge clk);
         if (at) begin
            ad = 1'b1;
            s_awvalid <= 1'b0;
         end
         if (wt) begin
            wd = 1'b1;
            s_wvalid <= 1'b0;
         end
      end
      s_bready <= 1'b1;
      do begin
         @(negedge clk);
         at = s_bvalid;
         r = s_bresp;
         @(posedge clk);
      end while (!at);
      s_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic t;
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      do begin
         @(negedge clk);
         t = s_arready;
         @(posedge clk);
      end while (!t);
      s_arvalid <= 1'b0;
      s_rready <= 1'b1;
      do begin
         @(negedge clk);
         t = s_rvalid;
         d = s_rdata;
         r = s_rresp;
         @(posedge clk);
      end while (!t);
      s_rready <= 1'b0;
   endtask

   task automatic pulse(input int which);
      if (which == 0) sleep_req <= 1'b1;
      if (which == 1) irq_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
      irq_req <= 1'b0;
      @(negedge clk);
      @(posedge clk);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("mode_after_reset", 32'(msm_pkg::MSM_EXEC), 32'(mode_state));
      check("clk_en_reset", 32'h0, 32'(periph_clk_en));
      check("prst_reset", 32'h1, 32'(periph_rst));
      axi_read(msm_pkg::MSM_OFF_CTRL_A, rd, rsp);
      check("ctrl_a_reset", 32'h0000_00ff, rd);
      axi_read(msm_pkg::MSM_OFF_CTRL_B, rd, rsp);
      check("ctrl_b_reset", 32'h0000_00ff, rd);
      // control B writes keep bits 7:5 at one; control A is written with 8'h7c, clearing bits 7, 1 and 0
      axi_write(msm_pkg::MSM_OFF_CTRL_A, 32'h0000_007c, rsp);
      axi_read(msm_pkg::MSM_OFF_CTRL_A, rd, rsp);
      check("ctrl_a_rw", 32'h0000_007c, rd);
      for (int i = 0; i < 5; i++) begin
         axi_write(msm_pkg::MSM_OFF_CTRL_B, 32'h0000_00ff & ~(32'h1 << i), rsp);
         check("ctrl_b_bresp", 32'(msm_pkg::MSM_RESP_OKAY), 32'(rsp));
         axi_read(msm_pkg::MSM_OFF_CTRL_B, rd, rsp);
         check("ctrl_b_rw", 32'h0000_00ff & ~(32'h1 << i), rd);
         @(negedge clk);
         check("clk_en_one", 32'h1 << i, 32'(periph_clk_en));
         check("prst_one", (i == 0) ? 32'h0 : 32'h1, 32'(periph_rst));
      end
      axi_read(32'h0000_0010, rd, rsp);
      check("unmapped_rresp", 32'(msm_pkg::MSM_RESP_SLVERR), 32'(rsp));
      check("unmapped_rdata", 32'h0, rd);
      axi_write(32'h0000_0010, 32'h0, rsp);
      check("unmapped_bresp", 32'(msm_pkg::MSM_RESP_SLVERR), 32'(rsp));
      axi_read(msm_pkg::MSM_OFF_MODE, rd, rsp);
      check("mode_rdata", 32'(msm_pkg::MSM_EXEC), rd);
      check("mode_rresp", 32'(msm_pkg::MSM_RESP_OKAY), 32'(rsp));
      axi_write(msm_pkg::MSM_OFF_MODE, 32'h0000_0004, rsp);
      check("mode_bresp", 32'(msm_pkg::MSM_RESP_OKAY), 32'(rsp));
      check("mode_read_only", 32'(msm_pkg::MSM_EXEC), 32'(mode_state));
      // low byte strobe off: register must keep its value
      wr_strb = 4'he;
      axi_write(msm_pkg::MSM_OFF_CTRL_A, 32'h0000_00ff, rsp);
      check("nostrb_bresp", 32'(msm_pkg::MSM_RESP_OKAY), 32'(rsp));
      axi_read(msm_pkg::MSM_OFF_CTRL_A, rd, rsp);
      check("ctrl_a_nostrb", 32'h0000_007c, rd);
      wr_strb = 4'hf;
      pulse(0);
      check("mode_halt", 32'(msm_pkg::MSM_HALT), 32'(mode_state));
      pulse(1);
      check("mode_exec", 32'(msm_pkg::MSM_EXEC), 32'(mode_state));
      // frozen: a sleep request and the bus are ignored while ce is low
      ce <= 1'b0;
      sleep_req <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("mode_frozen", 32'(msm_pkg::MSM_EXEC), 32'(mode_state));
      check("arready_frozen", 32'h0, 32'(s_arready));
      check("clk_en_frozen", 32'h0000_0010, 32'(periph_clk_en));
      @(posedge clk);
      ce <= 1'b1;
      sleep_req <= 1'b0;
      repeat (2) @(posedge clk);
      check("mode_thawed", 32'(msm_pkg::MSM_EXEC), 32'(mode_state));
      pulse(0);
      rst_req <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      check("mode_reset", 32'(msm_pkg::MSM_RESET), 32'(mode_state));
      @(posedge clk);
      rst_req <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("mode_resume", 32'(msm_pkg::MSM_EXEC), 32'(mode_state));
      axi_read(msm_pkg::MSM_OFF_CTRL_B, rd, rsp);
      check("ctrl_b_reload", 32'h0000_00ff, rd);
      complete_run();
   end
endmodule
`default_nettype wire
